//--- core/can_irq_init_busoff_control.sv
// Interrupts, flag acknowledge, mode sequencing and bus-off recovery of a CAN controller
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "can_ctl_cfg.svh"
module can_irq_init_busoff_control
  import can_ctl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [3:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]     avs_readdata,
  output logic            avs_waitrequest,
  input  wire logic [2:0] tx_buf_idle,
  input  wire logic       rx_fg_load,
  input  wire logic       rx_fg_valid,
  input  wire logic       rx_fifo_overrun,
  input  wire logic [1:0] tx_err_state,
  input  wire logic [1:0] rx_err_state,
  input  wire logic       busoff_entry,
  input  wire logic       recessive_run,
  input  wire logic       bus_active_pin,
  input  wire logic       engine_idle,
  input  wire logic       cpu_stop,
  input  wire logic       cpu_wait,
  output logic            irq_wake,
  output logic            irq_error,
  output logic            irq_rx,
  output logic            irq_tx,
  output logic            sleep_ack,
  output logic            init_ack,
  output logic            power_down,
  output logic            bus_off,
  output logic            tx_load_req
);
  typedef struct packed {
    logic         wait_q;
    logic [31:0]  rdata;
    logic [7:0]   ctrl;
    logic [7:0]   ctrl1;
    logic         hold;
    logic [7:0]   rx_en;
    logic [2:0]   tx_en;
    logic [1:0]   tx_st;
    logic [1:0]   rx_st;
    sleep_state_t slp;
    logic         slept;
    logic         ini;
    busoff_state_t bo;
    logic [7:0]   seq_cnt;
    logic         cnt_done;
    logic         pin_s1;
    logic         pin_s2;
    logic [3:0]   irq;
    logic         pd;
    logic         txreq;
    logic         wreq;
    logic         slp_ack;
    logic         boff;
  } ctl_state_t;
  ctl_state_t s;
  ctl_state_t n;
  flag_if fl_wake ();
  flag_if fl_stch ();
  flag_if fl_ovr ();
  flag_if fl_full ();
  flag_if fl_tx [3] ();
  logic       acc;
  logic       wr_rf;
  logic       wr_tf;
  logic       in_sleep;
  logic       pd_now;
  logic [2:0] tx_buf_empty_flag;
  assign acc   = (avs_read || avs_write) && s.wait_q;
  assign wr_rf = avs_write && s.wait_q && (avs_address == `OFF_RX_FLAG);
  assign wr_tf = avs_write && s.wait_q && (avs_address == `OFF_TX_FLAG);
  assign in_sleep = s.ctrl[`CTRL_SLEEP_REQ] && (s.slp == MODE_SLEEP);
  assign pd_now = s.ctrl1[`CTRL1_ENABLE] && (cpu_stop || (cpu_wait && s.ctrl[`CTRL_STOP_WAIT]));
  sticky_flag u_wake (.clk(clk), .rst(rst), .ce(ce), .f(fl_wake));
  sticky_flag u_stch (.clk(clk), .rst(rst), .ce(ce), .f(fl_stch));
  sticky_flag u_ovr  (.clk(clk), .rst(rst), .ce(ce), .f(fl_ovr));
  sticky_flag u_full (.clk(clk), .rst(rst), .ce(ce), .f(fl_full));
  // Wake only after sleep with wake enabled
  assign fl_wake.set_evt = s.pin_s2 && s.ctrl[`CTRL_WAKE_EN] && (in_sleep || (s.pd && s.slept));
  assign fl_wake.clr_req = wr_rf && avs_writedata[`RF_WAKE];
  assign fl_wake.cond    = 1'b0;
  assign fl_stch.set_evt = (tx_err_state != s.tx_st) || (rx_err_state != s.rx_st);
  assign fl_stch.clr_req = wr_rf && avs_writedata[`RF_STCH];
  assign fl_stch.cond    = 1'b0;
  assign fl_ovr.set_evt = rx_fifo_overrun;
  assign fl_ovr.clr_req = wr_rf && avs_writedata[`RF_OVR];
  assign fl_ovr.cond    = 1'b0;
  // Foreground load after end of frame; no shift while asleep
  assign fl_full.set_evt = rx_fg_load && !in_sleep;
  assign fl_full.clr_req = wr_rf && avs_writedata[`RF_FULL];
  assign fl_full.cond    = 1'b0;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tx
      sticky_flag u_txe (.clk(clk), .rst(rst), .ce(ce), .f(fl_tx[gi]));
      assign fl_tx[gi].set_evt = 1'b0;
      assign fl_tx[gi].cond    = tx_buf_idle[gi];
      assign fl_tx[gi].clr_req = wr_tf && avs_writedata[gi];
      assign tx_buf_empty_flag[gi]           = fl_tx[gi].value;
    end
  endgenerate
  always_comb begin
    n = s;
    n.pin_s1 = bus_active_pin;
    n.pin_s2 = s.pin_s1;
    n.tx_st  = tx_err_state;
    n.rx_st  = rx_err_state;
    n.wait_q = (avs_read || avs_write) && !s.wait_q;
    n.rdata  = 32'h0;
    if (avs_read && !s.wait_q) begin
      unique case (avs_address)
        `OFF_CTRL:      n.rdata = {24'h0, s.ctrl};
        `OFF_STATUS:    n.rdata = {26'h0, s.pd, in_sleep, s.bo != BUS_ACTIVE, s.cnt_done, s.ini, s.slp == MODE_SLEEP};
        // Separate tx and rx state fields
        `OFF_RX_FLAG:   n.rdata = {24'h0, fl_wake.value, fl_stch.value, s.rx_st, s.tx_st,
                                   fl_ovr.value, fl_full.value};
        `OFF_RX_IRQ_EN: n.rdata = {24'h0, s.rx_en};
        `OFF_TX_FLAG:   n.rdata = {29'h0, tx_buf_empty_flag};
        `OFF_TX_IRQ_EN: n.rdata = {29'h0, s.tx_en};
        `OFF_MISC:      n.rdata = {31'h0, s.hold};
        `OFF_CTRL1:     n.rdata = {24'h0, s.ctrl1};
        default:        n.rdata = 32'h0;
      endcase
    end
    if (avs_write && s.wait_q) begin
      unique case (avs_address)
        `OFF_CTRL: begin
          n.ctrl = avs_writedata[7:0];
          // Sleep request cannot drop before ack
          if (s.ctrl[`CTRL_SLEEP_REQ] && s.slp == MODE_SLEEP_PEND) begin
            n.ctrl[`CTRL_SLEEP_REQ] = 1'b1;
          end
        end
        `OFF_RX_IRQ_EN: n.rx_en = avs_writedata[7:0];
        `OFF_TX_IRQ_EN: n.tx_en = avs_writedata[2:0];
        `OFF_MISC:      n.hold  = s.hold & ~avs_writedata[`MISC_HOLD];
        `OFF_CTRL1: begin
          if (s.ini) begin
            n.ctrl1 = avs_writedata[7:0];
          end else begin
            n.ctrl1[`CTRL1_ENABLE] = avs_writedata[`CTRL1_ENABLE];
          end
        end
        default: n.ctrl = s.ctrl;
      endcase
    end
    n.ini = s.ctrl[`CTRL_INIT_REQ];
    unique case (s.slp)
      MODE_NORMAL: if (s.ctrl[`CTRL_SLEEP_REQ]) n.slp = MODE_SLEEP_PEND;
      MODE_SLEEP_PEND: if (engine_idle && !s.txreq) n.slp = MODE_SLEEP;
      MODE_SLEEP: begin
        if (!s.ctrl[`CTRL_SLEEP_REQ] || (s.pin_s2 && s.ctrl[`CTRL_WAKE_EN])) begin
          n.slp = MODE_NORMAL;
          n.ctrl[`CTRL_SLEEP_REQ] = 1'b0;
        end
      end
    endcase
    n.pd = pd_now;
    if (pd_now && !s.pd) begin
      n.slept = in_sleep;
    end
    unique case (s.bo)
      BUS_ACTIVE: if (busoff_entry) begin
        n.bo       = BUS_OFF_COUNT;
        n.seq_cnt  = 8'h0;
        n.cnt_done = 1'b0;
        n.hold     = s.ctrl1[`CTRL1_USER_REC];
      end
      BUS_OFF_COUNT: if (recessive_run && !in_sleep && !s.pd) begin
        n.seq_cnt = s.seq_cnt + 8'h1;
        if (s.seq_cnt == `BUSOFF_SEQ_COUNT - 8'h1) begin
          n.cnt_done = 1'b1;
          n.bo       = BUS_OFF_WAIT;
        end
      end
      BUS_OFF_WAIT: if (!s.ctrl1[`CTRL1_USER_REC] || !n.hold) begin
        n.bo       = BUS_ACTIVE;
        n.cnt_done = 1'b0;
      end
    endcase
    n.txreq = |(~tx_buf_empty_flag & s.tx_en);
    n.irq[0] = fl_wake.value && s.rx_en[`RF_WAKE];
    n.irq[1] = (fl_stch.value && s.rx_en[`RF_STCH]) || (fl_ovr.value && s.rx_en[`RF_OVR]);
    n.irq[2] = fl_full.value && s.rx_en[`RF_FULL];
    n.irq[3] = |(tx_buf_empty_flag & s.tx_en);
    // Registered copies so every status output leaves a flip-flop
    n.wreq    = !n.wait_q;
    n.slp_ack = (n.slp == MODE_SLEEP);
    n.boff    = (n.bo != BUS_ACTIVE);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s       <= '0;
      s.ctrl  <= `RST_CTRL;
      s.ctrl1 <= `RST_CTRL1;
      s.slp   <= MODE_NORMAL;
      s.bo    <= BUS_ACTIVE;
      s.wreq  <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end
  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.wreq;
  assign irq_wake        = s.irq[0];
  assign irq_error       = s.irq[1];
  assign irq_rx          = s.irq[2];
  assign irq_tx          = s.irq[3];
  assign sleep_ack       = s.slp_ack;
  assign init_ack        = s.ini;
  assign power_down      = s.pd;
  assign bus_off         = s.boff;
  assign tx_load_req     = s.txreq;
  a_irq_rx_follow: assert property (@(posedge clk) disable iff (rst)
    ce && fl_full.value && s.rx_en[`RF_FULL] |=> irq_rx)
    else $error("receive interrupt not asserted");
  a_irq_tx_mask: assert property (@(posedge clk) disable iff (rst)
    ce && !(|(tx_buf_empty_flag & s.tx_en)) |=> !irq_tx)
    else $error("transmit interrupt without enabled flag");
  a_wake_needs_en: assert property (@(posedge clk) disable iff (rst)
    ce && fl_wake.set_evt |-> s.ctrl[`CTRL_WAKE_EN])
    else $error("wake flag set without wake enable");
  a_ovr_sets_flag: assert property (@(posedge clk) disable iff (rst)
    ce && rx_fifo_overrun |=> fl_ovr.value)
    else $error("overrun not flagged");
  a_pd_entry: assert property (@(posedge clk) disable iff (rst)
    ce && s.ctrl1[`CTRL1_ENABLE] && cpu_stop |=> power_down)
    else $error("stop mode without power-down");
  a_busoff_hold: assert property (@(posedge clk) disable iff (rst)
    ce && s.bo == BUS_OFF_WAIT && s.ctrl1[`CTRL1_USER_REC] && s.hold && !(acc && avs_write) |=> bus_off)
    else $error("bus-off left while held");
  a_busoff_auto: assert property (@(posedge clk) disable iff (rst)
    ce && s.bo == BUS_OFF_WAIT && !s.ctrl1[`CTRL1_USER_REC] |=> !bus_off)
    else $error("automatic recovery did not happen");
  a_stch_event: assert property (@(posedge clk) disable iff (rst)
    ce && (tx_err_state != s.tx_st) |=> fl_stch.value)
    else $error("status change not flagged");
  a_full_set: assert property (@(posedge clk) disable iff (rst)
    ce && rx_fg_load && !in_sleep |=> fl_full.value)
    else $error("receive full not set");
  c_wake_seen: cover property (@(posedge clk) disable iff (rst) irq_wake);
  c_busoff_exit: cover property (@(posedge clk) disable iff (rst) $fell(bus_off));
  c_sleep_ack: cover property (@(posedge clk) disable iff (rst) $rose(sleep_ack));
  c_error_irq: cover property (@(posedge clk) disable iff (rst) irq_error);
endmodule : can_irq_init_busoff_control

//--- core/can_ctl_cfg.svh
// Offsets, field positions, reset values and counts of the CAN control block
`ifndef CAN_CTL_CFG_SVH
`define CAN_CTL_CFG_SVH
`define OFF_CTRL          4'h0
`define OFF_STATUS        4'h1
`define OFF_RX_FLAG       4'h2
`define OFF_RX_IRQ_EN     4'h3
`define OFF_TX_FLAG       4'h4
`define OFF_TX_IRQ_EN     4'h5
`define OFF_MISC          4'h6
`define OFF_CTRL1         4'h7
// Control word bit positions
`define CTRL_INIT_REQ     0
`define CTRL_SLEEP_REQ    1
`define CTRL_WAKE_EN      2
`define CTRL_STOP_WAIT    3
`define CTRL1_ENABLE      0
`define CTRL1_USER_REC    1
`define MISC_HOLD         0
// Receive flag word: wake 7, status change 6, rx state 5:4, tx state 3:2, overrun 1, full 0
`define RF_WAKE           7
`define RF_STCH           6
`define RF_OVR            1
`define RF_FULL           0
`define RST_CTRL          8'h01
`define RST_CTRL1         8'h00
`define RST_TX_FLAG       3'h7
`define BUSOFF_SEQ_COUNT  8'h80
`define RECESSIVE_BITS    4'hb
`endif

//--- core/can_ctl_pkg.sv
// Types shared by the CAN control block modules
package can_ctl_pkg;
  typedef enum logic [1:0] {
    BUS_ACTIVE,
    BUS_OFF_COUNT,
    BUS_OFF_WAIT
  } busoff_state_t;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SLEEP_PEND,
    MODE_SLEEP
  } sleep_state_t;
endpackage : can_ctl_pkg

//--- core/flag_if.sv
// Interface carrying one sticky flag's set, clear, hold and value
`timescale 1ns/100ps
interface flag_if;
  logic set_evt;
  logic clr_req;
  logic cond;
  logic value;
  modport owner (input set_evt, input clr_req, input cond, output value);
  modport user  (output set_evt, output clr_req, output cond, input value);
endinterface : flag_if

//--- core/sticky_flag.sv
// One sticky event flag with write-one clear
`timescale 1ns/100ps
module sticky_flag (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  flag_if.owner     f
);
  typedef struct packed {
    logic value;
  } flag_state_t;
  flag_state_t st;
  flag_state_t next_st;
  assign f.value = st.value;
  always_comb begin
    next_st = st;
    if (f.clr_req && !f.cond) begin
      next_st.value = 1'b0;
    end
    if (f.set_evt || f.cond) begin
      next_st.value = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
  a_flag_set_wins: assert property (@(posedge clk) disable iff (rst)
    ce && f.set_evt |=> f.value)
    else $error("flag lost a set event");
  a_flag_cond_hold: assert property (@(posedge clk) disable iff (rst)
    ce && f.cond && f.clr_req |=> f.value)
    else $error("flag cleared while cause holds");
  a_flag_clear_ok: assert property (@(posedge clk) disable iff (rst)
    ce && f.value && f.clr_req && !f.cond && !f.set_evt |=> !f.value)
    else $error("write-one clear ignored");
endmodule : sticky_flag

//--- bench/can_bus_model.sv
// Frame engine and bus nodes seen from the control block
`timescale 1ns/100ps
module can_bus_model (
  input  wire logic clk,
  output logic [2:0] tx_buf_idle,
  output logic       rx_fg_load,
  output logic       rx_fifo_overrun,
  output logic [1:0] tx_err_state,
  output logic [1:0] rx_err_state,
  output logic       busoff_entry,
  output logic       recessive_run,
  output logic       bus_active_pin
);
  initial begin
    {rx_fg_load, rx_fifo_overrun, busoff_entry, recessive_run, bus_active_pin} = 5'h00;
    tx_buf_idle = 3'h7;
    {tx_err_state, rx_err_state} = 4'h0;
  end
  task set_levels(input logic [2:0] idle, input logic [1:0] txs, input logic [1:0] rxs);
    @(posedge clk);
    tx_buf_idle <= idle;
    tx_err_state <= txs;
    rx_err_state <= rxs;
  endtask : set_levels
  // Pulses of the selected lines
  // Lines: load, overrun, bus-off entry, recessive run, bus activity; bus idles low
  task pulse(input logic [4:0] sel, input int n);
    @(posedge clk);
    {rx_fg_load, rx_fifo_overrun, busoff_entry, recessive_run, bus_active_pin} <= sel;
    repeat (n) @(posedge clk);
    {rx_fg_load, rx_fifo_overrun, busoff_entry, recessive_run, bus_active_pin} <= 5'h00;
  endtask : pulse
endmodule : can_bus_model

//--- bench/can_irq_init_busoff_control_tb_top.sv
// Self-checking bench for the CAN interrupt, mode and bus-off control block
`timescale 1ns/100ps
`include "can_ctl_cfg.svh"
module can_irq_init_busoff_control_tb_top;
  typedef struct packed {
    logic [4:0] sel;
    logic [1:0] txs;
    logic [1:0] rxs;
    logic [7:0] flags;
    logic [1:0] irqs;
  } row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        cpu_stop = 1'b0;
  logic        cpu_wait = 1'b0;
  logic        ce = 1'b1;
  logic        tx_load_req;
  logic [2:0]  tx_buf_idle;
  logic [1:0]  tx_err_state, rx_err_state;
  logic        rx_fg_load, rx_fifo_overrun, busoff_entry, recessive_run, bus_active_pin;
  logic        irq_wake, irq_error, irq_rx, irq_tx, sleep_ack, init_ack, power_down, bus_off;
  logic [7:0]  q;
  int          err_count = 0;
  int          checks = 0;
  row_t        rows [5] = '{'{5'h10, 2'h0, 2'h0, 8'h01, 2'b01}, '{5'h08, 2'h0, 2'h0, 8'h02, 2'b10},
                            '{5'h00, 2'h1, 2'h0, 8'h44, 2'b10}, '{5'h00, 2'h1, 2'h2, 8'h64, 2'b10},
                            '{5'h10, 2'h1, 2'h2, 8'h25, 2'b01}};
  logic [3:0]  ra [6] = '{`OFF_CTRL, `OFF_STATUS, `OFF_TX_FLAG, `OFF_CTRL1, 4'h8, 4'hf};
  logic [7:0]  rv [6] = '{8'h01, 8'h02, 8'h07, 8'h00, 8'h00, 8'h00};

  always #5 clk = ~clk;

  can_bus_model bm (.clk(clk), .tx_buf_idle(tx_buf_idle), .rx_fg_load(rx_fg_load),
    .rx_fifo_overrun(rx_fifo_overrun), .tx_err_state(tx_err_state), .rx_err_state(rx_err_state),
    .busoff_entry(busoff_entry), .recessive_run(recessive_run), .bus_active_pin(bus_active_pin));

  can_irq_init_busoff_control can_irq_init_busoff_control_inst (.clk(clk), .rst(rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_buf_idle(tx_buf_idle),
    .rx_fg_load(rx_fg_load), .rx_fg_valid(1'b0), .rx_fifo_overrun(rx_fifo_overrun),
    .tx_err_state(tx_err_state), .rx_err_state(rx_err_state), .busoff_entry(busoff_entry),
    .recessive_run(recessive_run), .bus_active_pin(bus_active_pin), .engine_idle(1'b1),
    .cpu_stop(cpu_stop), .cpu_wait(cpu_wait), .irq_wake(irq_wake), .irq_error(irq_error),
    .irq_rx(irq_rx), .irq_tx(irq_tx), .sleep_ack(sleep_ack), .init_ack(init_ack),
    .power_down(power_down), .bus_off(bus_off), .tx_load_req(tx_load_req));

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : cmp8

  task cmp1(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, s);
    end
  endtask : cmp1

  // Holds the request until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) err_count++;
  endtask : bus

  function automatic logic pick(input int k);
    case (k)
      0: return init_ack;
      1: return sleep_ack;
      2: return bus_off;
      3: return irq_wake;
      4: return power_down;
      default: return irq_tx;
    endcase
  endfunction : pick

  task await(input string n, input int k, input logic v);
    for (int i = 0; i < 60 && pick(k) !== v; i++) @(posedge clk);
    cmp1(n, v, pick(k));
  endtask : await

  task runs(input int n);
    repeat (n) bm.pulse(5'h02, 1);
    repeat (3) @(posedge clk);
  endtask : runs

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmp1("init ack", 1'b1, init_ack);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 8'h00);
      cmp8("reset value", rv[i], q);
    end
    bus(1'b1, `OFF_CTRL1, 8'h01);
    bus(1'b1, `OFF_CTRL, 8'h00);
    await("init left", 0, 1'b0);
    cmp1("irq tx masked", 1'b0, irq_tx);
    bus(1'b1, `OFF_RX_IRQ_EN, 8'hc3);
    foreach (rows[i]) begin
      bm.set_levels(3'h7, rows[i].txs, rows[i].rxs);
      if (rows[i].sel != 5'h00) bm.pulse(rows[i].sel, 1);
      repeat (3) @(posedge clk);
      bus(1'b0, `OFF_RX_FLAG, 8'h00);
      cmp8("rx flags", rows[i].flags, q);
      cmp1("irq error", rows[i].irqs[1], irq_error);
      cmp1("irq rx", rows[i].irqs[0], irq_rx);
      bus(1'b1, `OFF_RX_FLAG, rows[i].flags & 8'hc3);
      bus(1'b0, `OFF_RX_FLAG, 8'h00);
      cmp8("rx flags cleared", rows[i].flags & 8'h3c, q);
      repeat (2) @(posedge clk);
      cmp1("irq error idle", 1'b0, irq_error);
    end
    bus(1'b1, `OFF_TX_IRQ_EN, 8'h07);
    await("irq tx", 5, 1'b1);
    bus(1'b1, `OFF_TX_FLAG, 8'h01);
    bus(1'b0, `OFF_TX_FLAG, 8'h00);
    cmp8("tx flags held", 8'h07, q);
    bm.set_levels(3'h6, 2'h1, 2'h2);
    bus(1'b1, `OFF_TX_FLAG, 8'h01);
    bus(1'b0, `OFF_TX_FLAG, 8'h00);
    cmp8("tx flags", 8'h06, q);
    bus(1'b1, `OFF_TX_IRQ_EN, 8'h01);
    await("irq tx off", 5, 1'b0);
    cmp1("tx load req", 1'b1, tx_load_req);
    bm.pulse(5'h04, 1);
    await("bus off", 2, 1'b1);
    runs(127);
    cmp1("bus off held", 1'b1, bus_off);
    runs(1);
    await("bus off left", 2, 1'b0);
    // Sleep is only granted once every transmit buffer enabled in tx_en is empty again
    bm.set_levels(3'h7, 2'h1, 2'h2);
    bus(1'b1, `OFF_CTRL, 8'h04);
    bus(1'b1, `OFF_CTRL, 8'h06);
    await("sleep ack", 1, 1'b1);
    cmp1("tx load idle", 1'b0, tx_load_req);
    bm.pulse(5'h01, 3);
    await("irq wake", 3, 1'b1);
    bus(1'b0, `OFF_RX_FLAG, 8'h00);
    cmp8("wake flag", 8'h80, q & 8'h80);
    bus(1'b1, `OFF_RX_FLAG, 8'h80);
    await("irq wake clear", 3, 1'b0);
    bus(1'b1, `OFF_CTRL, 8'h04);
    bus(1'b1, `OFF_CTRL, 8'h06);
    await("sleep ack again", 1, 1'b1);
    bus(1'b1, `OFF_CTRL, 8'h07);
    await("init ack again", 0, 1'b1);
    bus(1'b1, `OFF_CTRL1, 8'h03);
    bus(1'b1, `OFF_CTRL, 8'h04);
    await("init left again", 0, 1'b0);
    bm.pulse(5'h04, 1);
    await("bus off user", 2, 1'b1);
    runs(128);
    cmp1("bus off on hold", 1'b1, bus_off);
    bus(1'b1, `OFF_MISC, 8'h01);
    await("bus off released", 2, 1'b0);
    bm.pulse(5'h04, 1);
    bus(1'b1, `OFF_MISC, 8'h01);
    runs(127);
    cmp1("bus off counting", 1'b1, bus_off);
    runs(1);
    await("bus off count done", 2, 1'b0);
    // An event while the clock enable is low must be lost
    ce <= 1'b0;
    bm.pulse(5'h08, 1);
    ce <= 1'b1;
    bus(1'b0, `OFF_RX_FLAG, 8'h00);
    cmp8("frozen overrun", 8'h00, q & 8'h02);
    cpu_stop <= 1'b1;
    await("power down stop", 4, 1'b1);
    cpu_stop <= 1'b0;
    await("power up", 4, 1'b0);
    bus(1'b1, `OFF_CTRL, 8'h08);
    cpu_wait <= 1'b1;
    await("power down wait", 4, 1'b1);
    cpu_wait <= 1'b0;
    bus(1'b1, `OFF_CTRL, 8'h00);
    cpu_wait <= 1'b1;
    repeat (4) @(posedge clk);
    cmp1("no power down", 1'b0, power_down);
    // Second reset in mid-run restores the defaults
    cpu_wait <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmp1("init ack after reset", 1'b1, init_ack);
    cmp1("bus off after reset", 1'b0, bus_off);
    bus(1'b0, `OFF_CTRL1, 8'h00);
    cmp8("ctrl1 after reset", 8'h00, q);
    print_verdict();
  end

  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule : can_irq_init_busoff_control_tb_top
